// File: rtl/cec_top.sv
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps
// Notes on behaviour
// - Result is one when positive input exceeds negative input, else zero.
// - Bit 7 powers the comparator off; writable at any time.
// - Bit 6 with brown-out detector on selects internal reference as positive input.
// - Bit 5 is read-only and shows the comparator result; writes ignored.
// - Bit 4 event flag sets on a transition matching the selected mode.
// - Interrupt requested only while flag, irq enable and global enable are set.
// - Flag clears when the processor takes the comparator interrupt vector.
// - Writing one to bit 4 clears the flag; zero leaves it.
// - With bit 3 clear no interrupt is raised; flag may still set.
// - Bit 2 routes the result to timer capture front end; clear means none.
// - Mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
module cec_top
    import cec_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire cec_avs_req_s i_avs,
    output cec_avs_rsp_s o_avs,
    input wire logic i_comparator_raw,
    input wire logic i_brownout_detector_enabled,
    input wire logic i_global_irq_enable,
    input wire logic i_vector_taken,
    output logic o_comparator_power_off,
    output logic o_reference_internal,
    output logic o_capture_input,
    output logic o_irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    localparam cec_state_s STATE_RESET = '{
        bus: CEC_BUS_IDLE,
        waitrequest: 1'b1,
        readdata: '0,
        sync_a: 1'b0,
        sync_b: 1'b0,
        prev: 1'b0,
        power_off: CEC_CSR_RESET[CEC_BIT_POWER_OFF],
        ref_sel: CEC_CSR_RESET[CEC_BIT_REF_SEL],
        flag: CEC_CSR_RESET[CEC_BIT_FLAG],
        irq_en: CEC_CSR_RESET[CEC_BIT_IRQ_EN],
        cap_en: CEC_CSR_RESET[CEC_BIT_CAP_EN],
        mode: CEC_MODE_TOGGLE,
        irq: 1'b0,
        cap_in: 1'b0,
        ref_internal: 1'b0
    };

    cec_state_s st;
    cec_state_s next_st;
    logic rise;
    logic fall;
    logic event_hit;
    logic csr_hit;
    logic wr_fire;
    logic rd_fire;
    logic flag_clear;
    logic [7:0] csr_view;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Second flop is the only reader of the first
        next_st.sync_a = i_comparator_raw;
        next_st.sync_b = st.sync_a;
        next_st.prev = st.sync_b;

        rise = st.sync_b & ~st.prev;
        fall = ~st.sync_b & st.prev;
        case (st.mode)
            CEC_MODE_TOGGLE: begin
                event_hit = rise | fall;
            end
            CEC_MODE_FALL: begin
                event_hit = fall;
            end
            CEC_MODE_RISE: begin
                event_hit = rise;
            end
            default: begin
                event_hit = 1'b0;
            end
        endcase

        csr_view = 8'h00;
        csr_view[CEC_BIT_POWER_OFF] = st.power_off;
        csr_view[CEC_BIT_REF_SEL] = st.ref_sel;
        csr_view[CEC_BIT_RESULT] = st.sync_b;
        csr_view[CEC_BIT_FLAG] = st.flag;
        csr_view[CEC_BIT_IRQ_EN] = st.irq_en;
        csr_view[CEC_BIT_CAP_EN] = st.cap_en;
        csr_view[CEC_BIT_MODE_HI] = st.mode[1];
        csr_view[CEC_BIT_MODE_LO] = st.mode[0];

        // Two-cycle access: answer staged, then the write lands
        csr_hit = (i_avs.address == CEC_CSR_OFFSET);
        rd_fire = (st.bus == CEC_BUS_ANSWER) && i_avs.read;
        wr_fire = (st.bus == CEC_BUS_ANSWER) && i_avs.write && csr_hit && i_avs.byteenable[0];
        case (st.bus)
            CEC_BUS_IDLE: begin
                if (i_avs.read || i_avs.write) begin
                    next_st.bus = CEC_BUS_ANSWER;
                    next_st.waitrequest = 1'b0;
                    next_st.readdata = csr_hit ? {24'h000000, csr_view} : 32'h00000000;
                end
            end
            CEC_BUS_ANSWER: begin
                next_st.bus = CEC_BUS_IDLE;
                next_st.waitrequest = 1'b1;
            end
            default: begin
                next_st.bus = CEC_BUS_IDLE;
                next_st.waitrequest = 1'b1;
            end
        endcase

        if (wr_fire) begin
            next_st.power_off = i_avs.writedata[CEC_BIT_POWER_OFF];
            next_st.ref_sel = i_avs.writedata[CEC_BIT_REF_SEL];
            next_st.irq_en = i_avs.writedata[CEC_BIT_IRQ_EN];
            next_st.cap_en = i_avs.writedata[CEC_BIT_CAP_EN];
            next_st.mode = cec_mode_e'(i_avs.writedata[CEC_BIT_MODE_HI:CEC_BIT_MODE_LO]);
        end

        // A one written back by read-modify-write also clears it
        flag_clear = (wr_fire && i_avs.writedata[CEC_BIT_FLAG]) || i_vector_taken;
        // Set wins so an edge in the clearing cycle is kept
        next_st.flag = (st.flag & ~flag_clear) | event_hit;

        next_st.irq = next_st.flag & next_st.irq_en & i_global_irq_enable;
        next_st.cap_in = next_st.cap_en & st.sync_b;
        next_st.ref_internal = next_st.ref_sel & i_brownout_detector_enabled;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign o_avs = '{readdata: st.readdata, waitrequest: st.waitrequest};
    assign o_comparator_power_off = st.power_off;
    assign o_reference_internal = st.ref_internal;
    assign o_capture_input = st.cap_in;
    assign o_irq = st.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    result_sync_a: assert property (
        ##2 (st.sync_b == $past(i_comparator_raw, 2)))
        else $error("result not two samples behind the comparator");

    rise_flag_a: assert property (
        (st.mode == CEC_MODE_RISE && !st.prev && st.sync_b) |=> st.flag)
        else $error("rising edge did not set the flag");

    toggle_flag_a: assert property (
        (st.mode == CEC_MODE_TOGGLE && (rise || fall)) |=> st.flag)
        else $error("toggle did not set the flag");

    fall_mode_a: assert property (
        (st.mode == CEC_MODE_FALL && rise && !fall && !st.flag) |=> !st.flag)
        else $error("rising edge set the flag in falling mode");

    reserved_mode_a: assert property (
        (st.mode == CEC_MODE_RESERVED && !st.flag && !wr_fire) |=> !st.flag)
        else $error("reserved mode set the flag");

    flag_w1c_a: assert property (
        (wr_fire && i_avs.writedata[CEC_BIT_FLAG] && !event_hit) |=> !st.flag)
        else $error("write of one did not clear the flag");

    flag_w0_keep_a: assert property (
        (wr_fire && !i_avs.writedata[CEC_BIT_FLAG] && st.flag && !i_vector_taken) |=> st.flag)
        else $error("write of zero cleared the flag");

    vector_clear_a: assert property (
        (i_vector_taken && !event_hit) |=> !st.flag)
        else $error("vector did not clear the flag");

    irq_gate_a: assert property (
        o_irq |-> st.flag && st.irq_en)
        else $error("interrupt without flag and enable");

    irq_disabled_a: assert property (
        (!next_st.irq_en) |=> !o_irq)
        else $error("interrupt raised while disabled");

    power_off_a: assert property (
        wr_fire |=> (o_comparator_power_off == $past(i_avs.writedata[CEC_BIT_POWER_OFF])))
        else $error("power-off bit not taken from the write");

    result_read_a: assert property (
        rd_fire && csr_hit |-> (o_avs.readdata[CEC_BIT_RESULT] == $past(st.sync_b)))
        else $error("read of result does not match comparator");

    capture_route_a: assert property (
        o_capture_input |-> $past(st.sync_b) && st.cap_en)
        else $error("capture input driven without routing");

    ref_select_a: assert property (
        o_reference_internal |-> st.ref_sel && $past(i_brownout_detector_enabled))
        else $error("internal reference without select and detector");

    fall_flag_a: assert property (
        (st.mode == CEC_MODE_FALL && st.prev && !st.sync_b) |=> st.flag)
        else $error("falling edge did not set the flag");

    rise_skip_fall_a: assert property (
        (st.mode == CEC_MODE_RISE && fall && !st.flag) |=> !st.flag)
        else $error("falling edge set the flag in rising mode");

    // Losing an edge here would hide an event from software
    set_wins_a: assert property (
        (event_hit && flag_clear) |=> st.flag)
        else $error("clear won over a same-cycle event");

    flag_hold_a: assert property (
        (st.flag && !flag_clear) |=> st.flag)
        else $error("flag dropped without a clear");

    irq_global_a: assert property (
        o_irq |-> $past(i_global_irq_enable))
        else $error("interrupt without global enable");

    irq_request_a: assert property (
        (st.flag && st.irq_en && i_global_irq_enable && !flag_clear && !wr_fire) |=> o_irq)
        else $error("interrupt not requested with all enables set");

    irq_vector_a: assert property (
        (i_vector_taken && !event_hit) |=> !o_irq)
        else $error("interrupt kept after the vector was taken");

    ctrl_hold_a: assert property (
        (!wr_fire) |=> $stable({st.power_off, st.ref_sel, st.irq_en, st.cap_en, st.mode}))
        else $error("control bits changed without a write");

    mode_write_a: assert property (
        wr_fire |=> (st.mode == $past(i_avs.writedata[CEC_BIT_MODE_HI:CEC_BIT_MODE_LO])))
        else $error("event mode not taken from the write");

    capture_follow_a: assert property (
        st.cap_en |-> (o_capture_input == $past(st.sync_b)))
        else $error("capture input does not follow the result");

    ref_follow_a: assert property (
        (st.ref_sel && $past(i_brownout_detector_enabled)) |-> o_reference_internal)
        else $error("internal reference not selected");

    // Sync stages and edge detector taps must stay exactly one flop apart
    sync_first_a: assert property (
        1'b1 |=> (st.sync_b == $past(st.sync_a)))
        else $error("second sync stage skipped a sample");

    edge_prev_a: assert property (
        1'b1 |=> (st.prev == $past(st.sync_b)))
        else $error("previous sample not one clock behind");

    // ----------------------------------------------------------------
    // Register bus checks
    // ----------------------------------------------------------------
    read_upper_a: assert property (
        o_avs.readdata[CEC_DATA_W-1:8] == '0)
        else $error("upper read data bits not zero");

    unmapped_read_a: assert property (
        (st.waitrequest && i_avs.read && !csr_hit) |=> (o_avs.readdata == '0))
        else $error("unmapped read returned data");

    read_flag_a: assert property (
        rd_fire && csr_hit |-> (o_avs.readdata[CEC_BIT_FLAG] == $past(st.flag)))
        else $error("read of flag does not match");

    read_power_a: assert property (
        rd_fire && csr_hit |-> (o_avs.readdata[CEC_BIT_POWER_OFF] == $past(st.power_off)))
        else $error("read of power-off bit does not match");

    bus_answer_a: assert property (
        (st.waitrequest && (i_avs.read || i_avs.write)) |=> !o_avs.waitrequest ##1 o_avs.waitrequest)
        else $error("access not answered in one cycle");

    // ----------------------------------------------------------------
    // Scenario covers
    // ----------------------------------------------------------------
    read_cov: cover property (rd_fire && csr_hit);
    w1c_cov: cover property (wr_fire && i_avs.writedata[CEC_BIT_FLAG] && st.flag);
    irq_cov: cover property (!o_irq ##1 o_irq);
    set_clear_race_cov: cover property (event_hit && flag_clear);
    fall_event_cov: cover property (st.mode == CEC_MODE_FALL && event_hit);

endmodule

// File: common/cec_pkg.sv
package cec_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int CEC_ADDR_W = 8;
    localparam int CEC_DATA_W = 32;
    localparam logic [7:0] CEC_CSR_OFFSET = 8'h08;
    localparam logic [7:0] CEC_CSR_RESET = 8'h00;

    localparam int CEC_BIT_POWER_OFF = 7;
    localparam int CEC_BIT_REF_SEL = 6;
    localparam int CEC_BIT_RESULT = 5;
    localparam int CEC_BIT_FLAG = 4;
    localparam int CEC_BIT_IRQ_EN = 3;
    localparam int CEC_BIT_CAP_EN = 2;
    localparam int CEC_BIT_MODE_HI = 1;
    localparam int CEC_BIT_MODE_LO = 0;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CEC_MODE_TOGGLE = 2'h0,
        CEC_MODE_RESERVED = 2'h1,
        CEC_MODE_FALL = 2'h2,
        CEC_MODE_RISE = 2'h3
    } cec_mode_e;

    typedef enum logic [1:0] {
        CEC_BUS_IDLE = 2'h1,
        CEC_BUS_ANSWER = 2'h2
    } cec_bus_e;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [CEC_ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [CEC_DATA_W-1:0] writedata;
        logic [3:0] byteenable;
    } cec_avs_req_s;

    typedef struct packed {
        logic [CEC_DATA_W-1:0] readdata;
        logic waitrequest;
    } cec_avs_rsp_s;

    typedef struct packed {
        cec_bus_e bus;
        logic waitrequest;
        logic [CEC_DATA_W-1:0] readdata;
        logic sync_a;
        logic sync_b;
        logic prev;
        logic power_off;
        logic ref_sel;
        logic flag;
        logic irq_en;
        logic cap_en;
        cec_mode_e mode;
        logic irq;
        logic cap_in;
        logic ref_internal;
    } cec_state_s;

endpackage

// File: verif/cec_comparator_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Analog core stand-in
// ----------------------------------------------------------------
module cec_comparator_model #(
    parameter int REF_MV = 1220
) (
    input wire logic i_power_off,
    input wire logic i_ref_internal,
    input wire logic [15:0] i_pos_mv,
    input wire logic [15:0] i_neg_mv,
    output logic o_raw
);
    int pos;
    // Unpowered core is taken as a low output
    always_comb begin
        pos = i_ref_internal ? REF_MV : int'(i_pos_mv);
        o_raw = !i_power_off && (pos > int'(i_neg_mv));
    end
endmodule

// File: verif/tb.sv
`timescale 1ns/10ps
module tb
    import cec_pkg::*;
;
    localparam int REF_MV = 1220;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    cec_avs_req_s avs = '0;
    cec_avs_rsp_s rsp;
    logic raw, pwr, refi, cap, irq;
    logic brownout_detector = 1'b0, gie = 1'b0, vec = 1'b0;
    logic [15:0] pmv = 16'h0000;
    logic [15:0] nmv = 16'h05dc;
    logic pw = 1'b0, rs = 1'b0, res = 1'b0, flag = 1'b0, ie = 1'b0, ce = 1'b0;
    logic [1:0] md = 2'h0;
    int fail_count = 0;
    int n_checks = 0;

    initial begin
        forever #2.5 i_clock = ~i_clock;
    end

    cec_top u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_avs(avs), .o_avs(rsp), .i_comparator_raw(raw),
        .i_brownout_detector_enabled(brownout_detector), .i_global_irq_enable(gie), .i_vector_taken(vec),
        .o_comparator_power_off(pwr), .o_reference_internal(refi), .o_capture_input(cap), .o_irq(irq));
    cec_comparator_model #(.REF_MV(REF_MV)) u_core (.i_power_off(pwr), .i_ref_internal(refi),
        .i_pos_mv(pmv), .i_neg_mv(nmv), .o_raw(raw));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge i_clock);
        avs.address <= a;
        avs.read <= !wr;
        avs.write <= wr;
        avs.writedata <= {24'h000000, d};
        avs.byteenable <= 4'hf;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (rsp.waitrequest !== 1'b0);
        chk(32'(n < 20), 32'h1);
        q = rsp.readdata;
        avs.read <= 1'b0;
        avs.write <= 1'b0;
    endtask

    // Allows sync, edge and flag latency before judging
    task settle;
        logic r;
        logic [31:0] q;
        repeat (6) @(posedge i_clock);
        r = !pw && (((rs && brownout_detector) ? REF_MV : int'(pmv)) > int'(nmv));
        if (r != res && (md == 2'h0 || md == {1'b1, r})) flag = 1'b1;
        res = r;
        bus(1'b0, 8'h08, 8'h00, q);
        chk(q, {24'h0, pw, rs, res, flag, ie, ce, md});
        // Capture irq enable lives in the timer; only the routed level is judged
        chk(32'({pwr, refi, cap, irq}), 32'({pw, rs && brownout_detector, ce && res, flag && ie && gie}));
    endtask

    task wr(input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, 8'h08, d, q);
        {pw, rs} = d[7:6];
        ie = d[3];
        ce = d[2];
        md = d[1:0];
        if (d[4]) flag = 1'b0;
        settle();
    endtask

    task setv(input logic [15:0] v);
        @(posedge i_clock);
        pmv <= v;
        settle();
    endtask

    task give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] q;
        void'($urandom(55));
        repeat (12) @(posedge i_clock);
        i_rst_n <= 1'b1;
        settle();
        bus(1'b0, 8'h0c, 8'h00, q);
        chk(q, 32'h0);
        $display("reset test done");
        gie <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            // Interrupt off while the mode changes
            wr(8'h10 | 8'(m));
            // Start each mode from a low result with the flag clear
            setv(16'h0000);
            wr(8'h18 | 8'(m));
            for (int k = 0; k < 4; k++) begin
                setv(k[0] ? 16'(1501 + $urandom_range(0, 1000)) : 16'($urandom_range(0, 1500)));
            end
            $display("mode test done");
        end
        wr(8'h0b);
        wr(8'h3b);
        setv(16'h0000);
        setv(16'h07d0);
        vec <= 1'b1;
        @(posedge i_clock);
        vec <= 1'b0;
        flag = 1'b0;
        settle();
        gie <= 1'b0;
        setv(16'h0000);
        setv(16'h07d0);
        gie <= 1'b1;
        wr(8'h03);
        $display("flag test done");
        // Interrupt kept off around power and reference changes
        brownout_detector <= 1'b1;
        wr(8'h40);
        for (int k = 0; k < 8; k++) begin
            // Detector change moves the result while the reference is selected
            brownout_detector <= 1'($urandom);
            settle();
            wr(8'($urandom) & 8'hf7);
            setv(16'($urandom_range(0, 3000)));
        end
        $display("control test done");
        give_verdict();
    end

    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
endmodule
